/* sia_flag_bank.sv */
// bank of sticky status flags, hardware and software set, software clear
// assumes all strobes are one-cycle pulses on pclk
`timescale 1ns/1ps
module sia_flag_bank #(
  parameter int unsigned N = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // strobes
  input  wire logic [N-1:0] hw_set_i,
  input  wire logic [N-1:0] sw_set_i,
  input  wire logic [N-1:0] sw_clr_i,
  // state
  output logic      [N-1:0] st_o
);
  import sia_pkg::*;

  // set wins so that an event in the clear cycle is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_o <= N'(RST_REG);
    else st_o <= (st_o & ~sw_clr_i) | sw_set_i | hw_set_i;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_FLAG_SETWINS: assert property ((hw_set_i & sw_clr_i) != '0 |=>
    (st_o & $past(hw_set_i & sw_clr_i)) == $past(hw_set_i & sw_clr_i))
    else $error("clear beat a hardware set");
  AST_FLAG_CLEAR: assert property (sw_clr_i != '0 |=>
    (st_o & $past(sw_clr_i & ~sw_set_i & ~hw_set_i)) == '0)
    else $error("software clear had no effect");
endmodule // sia_flag_bank

/* sia_irq_sink.sv */
// interrupt controller stand-in: counts cycles that each request is high
// assumes requests are pclk-synchronous pulses from the aggregator
`timescale 1ns/1ps
module sia_irq_sink (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // request lines, nmi at the top
  input  wire logic [10:0]       irq,
  // high-cycle counts per line
  output logic      [10:0][7:0]  cnt
);
  //////////////////////////////////////////////////////////////////////
  // count high cycles, not edges, so a stretched pulse is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else begin
      for (int i = 0; i < 11; i++) begin
        cnt[i] <= cnt[i] + 8'(irq[i]);
      end
    end
  end
endmodule // sia_irq_sink

/* sia_pkg.sv */
// constants, register map and helpers of the interrupt aggregator
// assumes one 200 MHz clock and an APB master with 32-bit data
package sia_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned FILT_TIME_NS  = 1000;
  localparam int unsigned FILT_CYC      = (FILT_TIME_NS * 1000) /
                                          CLK_PERIOD_PS;
  localparam int unsigned FILT_CW       = 8;
  localparam logic [FILT_CW-1:0] FILT_LAST = FILT_CW'(FILT_CYC - 1);

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned NUM_TMR     = 6;
  localparam int unsigned NUM_HV      = 3;
  localparam int unsigned NUM_EXT     = 4;
  localparam int unsigned NUM_PIN_SEL = 4;
  localparam int unsigned NUM_XFER    = 8;
  localparam int unsigned NUM_CLK     = 3;
  localparam int unsigned NUM_WARN    = 5;
  localparam int unsigned NUM_PIN     = NUM_HV + NUM_EXT * NUM_PIN_SEL;

  // field positions
  localparam int unsigned EDGE_RISE_BIT    = 0;
  localparam int unsigned EDGE_FALL_BIT    = 1;
  localparam int unsigned EXT_CFG_W        = 4;
  localparam int unsigned EXT_SEL_LSB      = 2;
  localparam int unsigned HV_FALL_LSB      = 3;
  localparam int unsigned EXT_FALL_LSB     = 4;
  localparam int unsigned XFER_ERR_EN_BIT  = 8;
  localparam logic [31:0] RST_REG          = 32'h0;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_NP_WARN  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_NP_TMR   = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_NP_HV    = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_NP_EXT   = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_NP_XFER  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CLK_EN   = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_CLK_ST   = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_CLK_CLR  = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_CLK_SET  = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_HV_EN    = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_HV_ST    = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_HV_CLR   = 8'h5C;
  localparam logic [ADDR_W-1:0] OFS_HV_SET   = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_HV_CFG   = 8'h64;
  localparam logic [ADDR_W-1:0] OFS_EXT_EN   = 8'h68;
  localparam logic [ADDR_W-1:0] OFS_EXT_ST   = 8'h6C;
  localparam logic [ADDR_W-1:0] OFS_EXT_CLR  = 8'h70;
  localparam logic [ADDR_W-1:0] OFS_EXT_SET  = 8'h74;
  localparam logic [ADDR_W-1:0] OFS_EXT_CFG  = 8'h78;
  localparam logic [ADDR_W-1:0] OFS_TMR_EN   = 8'h7C;
  localparam logic [ADDR_W-1:0] OFS_TMR_ST   = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_TMR_CLR  = 8'h84;
  localparam logic [ADDR_W-1:0] OFS_TMR_SET  = 8'h88;
  localparam logic [ADDR_W-1:0] OFS_XFER_EN  = 8'h8C;
  localparam logic [ADDR_W-1:0] OFS_XFER_ST  = 8'h90;
  localparam logic [ADDR_W-1:0] OFS_XFER_CLR = 8'h94;
  localparam logic [ADDR_W-1:0] OFS_XFER_SET = 8'h98;

  // fresh requests split onto line 1 (pointer bit set) or line 0
  function automatic logic [1:0] sia_route2(logic [15:0] fire,
                                            logic [15:0] ptr);
    return {|(fire & ptr), |(fire & ~ptr)};
  endfunction
endpackage

/* sia_spike_filter.sv */
// spike filter with edge pulses for one synchronised input
// assumes din is already two-flop synchronised to pclk
`timescale 1ns/1ps
module sia_spike_filter (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // filtered signal
  input  wire logic din,
  output logic      rise_o,
  output logic      fall_o
);
  import sia_pkg::*;
  logic               level_q;
  logic [FILT_CW-1:0] cnt_q;

  // a level must persist FILT_CYC cycles before it is accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      cnt_q   <= '0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (din == level_q) begin
        cnt_q <= '0; // spike shorter than window is dropped
      end else if (cnt_q == FILT_LAST) begin
        level_q <= din;
        cnt_q   <= '0;
        rise_o  <= din;
        fall_o  <= !din;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_FILT_SPIKE: assert property (!$stable(din) |->
    ##1 (!rise_o && !fall_o)[*8]) else $error("spike passed filter");
endmodule // sia_spike_filter

/* sia_tb_top.sv */
// self-checking bench for the aggregator: apb tasks and event pulses
// assumes the designer's sia_pkg and one 200 MHz clock
`timescale 1ns/1ps
module sia_tb_top;
  import sia_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [23:0]       ev;
  logic [2:0]        hv;
  logic [15:0]       pin;
  logic              xerr, er;
  wire  [10:0]       irq;
  logic [10:0][7:0]  cnt;
  int                fails, cmp_count, cyc;
  //////////////////////////////////////////////////////////////////////
  // clock and cycle ceiling; the tests need under 2000 cycles
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////
  sia_top sia_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_evt(ev[5:0]),
    .hv_sense_comparator_out(hv), .ext_pin_in(pin),
    .transfer_done_evt(ev[13:6]), .transfer_error_request(xerr),
    .clock_fault_evt(ev[16:14]), .mem_fault_evt(ev[17]),
    .conv_err_evt(ev[18]), .warn_evt(ev[23:19]), .timer_irq(irq[1:0]),
    .hv_sense_irq(irq[3:2]), .ext_pin_irq(irq[5:4]),
    .transfer_irq(irq[7:6]), .warn_irq(irq[9:8]), .nmi_req(irq[10]));
  sia_irq_sink sia_irq_sink_inst (
    .pclk(pclk), .presetn(presetn), .irq(irq), .cnt(cnt));
  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; holds everything until pready is sampled high,
  // only the cycle ceiling ends a wait that never sees ready
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic cc(input int i, input logic [31:0] e);
    chk(32'(cnt[i]), e);
  endtask
  // one-cycle event pulse, then time for flag and request to land
  task automatic fire(input logic [23:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= '0;
    tick(4);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, xerr, er} = '0;
    {paddr, pwdata, ev, hv, pin, rd} = '0;
    {fails, cmp_count, cyc} = '0;
    tick(6);
    presetn <= 1'b1;
    rdc(OFS_TMR_ST, RST_REG);
    rdc(8'hFC, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(OFS_TMR_EN, 32'h1);
    fire(24'h1);
    cc(0, 1);
    fire(24'h1);
    cc(0, 1);
    wr(OFS_TMR_CLR, 32'h1);
    rdc(OFS_TMR_ST, 32'h0);
    wr(OFS_NP_TMR, 32'h1);
    wr(OFS_TMR_SET, 32'h1);
    tick(2);
    cc(1, 1);
    fire(24'h2);
    wr(OFS_TMR_ST, 32'h0);
    rdc(OFS_TMR_ST, 32'h3);
    cc(1, 1);
    wr(OFS_XFER_EN, 32'h180);
    fire(24'h2000);
    cc(6, 1);
    rdc(OFS_XFER_ST, 32'h80);
    wr(OFS_XFER_CLR, 32'h80);
    rdc(OFS_XFER_ST, 32'h0);
    xerr <= 1'b1;
    tick(4);
    cc(6, 2);
    xerr <= 1'b0;
    wr(OFS_XFER_SET, 32'h80);
    tick(2);
    cc(6, 3);
    wr(OFS_CLK_EN, 32'h4);
    fire(24'h10000);
    cc(10, 1);
    fire(24'h4000);
    rdc(OFS_CLK_ST, 32'h5);
    cc(10, 1);
    fire(24'h20000);
    fire(24'h40000);
    cc(10, 3);
    fire(24'h800000);
    cc(8, 1);
    wr(OFS_NP_WARN, 32'h1);
    fire(24'h80000);
    cc(9, 1);
    cc(8, 1);
    // channel 0 watches candidate B, rising edges only
    wr(OFS_EXT_CFG, 32'h5);
    wr(OFS_EXT_EN, 32'h1);
    pin <= 16'h3;
    tick(50);
    pin <= 16'h1;
    tick(250);
    cc(4, 0);
    pin <= 16'h3;
    tick(250);
    cc(4, 1);
    rdc(OFS_EXT_ST, 32'h1);
    // sense input 0 on falling edges only
    wr(OFS_HV_CFG, 32'h2);
    wr(OFS_HV_EN, 32'h1);
    hv <= 3'h1;
    tick(250);
    cc(2, 0);
    hv <= 3'h0;
    tick(250);
    cc(2, 1);
    rdc(OFS_HV_ST, 32'h8);
    wr(OFS_HV_CLR, 32'h8);
    rdc(OFS_HV_ST, 32'h0);
    tally_and_finish();
  end
endmodule // sia_tb_top

/* sia_top.sv */
// interrupt and exception aggregation with APB register access
// assumes event inputs are pclk-synchronous pulses; sense and pin
// inputs are asynchronous and synchronised here
`timescale 1ns/1ps
module sia_top (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [sia_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // event sources
  input  wire logic [sia_pkg::NUM_TMR-1:0]  timer_evt,
  input  wire logic [sia_pkg::NUM_HV-1:0]   hv_sense_comparator_out,
  input  wire logic [15:0]                  ext_pin_in,
  input  wire logic [sia_pkg::NUM_XFER-1:0] transfer_done_evt,
  input  wire logic                         transfer_error_request,
  input  wire logic [sia_pkg::NUM_CLK-1:0]  clock_fault_evt,
  input  wire logic                         mem_fault_evt,
  input  wire logic                         conv_err_evt,
  input  wire logic [sia_pkg::NUM_WARN-1:0] warn_evt,
  // request pulses toward the interrupt controller
  output logic [1:0]                        timer_irq,
  output logic [1:0]                        hv_sense_irq,
  output logic [1:0]                        ext_pin_irq,
  output logic [1:0]                        transfer_irq,
  output logic [1:0]                        warn_irq,
  output logic                              nmi_req
);
  import sia_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic                 acc_go, wr_en, rd_hit;
  logic [31:0]          rd_data;
  logic                 np_warn_q, np_tmr_q, np_xfer_q;
  logic [NUM_HV-1:0]    np_hv_q, hv_en_q;
  logic [NUM_EXT-1:0]   np_ext_q, ext_en_q;
  logic [2*NUM_HV-1:0]  hv_cfg_q;
  logic [15:0]          ext_cfg_q;
  logic [NUM_TMR-1:0]   tmr_en_q;
  logic [8:0]           xfer_en_q;
  logic [NUM_CLK-1:0]   clk_en_q;
  logic [NUM_PIN-1:0]   pin_m_q, pin_s_q;
  logic [NUM_HV-1:0]    hv_rise, hv_fall;
  logic [NUM_EXT-1:0]   ext_pick, ext_rise, ext_fall;
  logic [2*NUM_HV-1:0]  hv_hw, hv_st;
  logic [2*NUM_EXT-1:0] ext_hw, ext_st;
  logic [NUM_TMR-1:0]   tmr_st, tmr_req, tmr_prev_q;
  logic [NUM_XFER-1:0]  xfer_st;
  logic [8:0]           xfer_req, xfer_prev_q;
  logic [NUM_CLK-1:0]   clk_st, clk_req, clk_prev_q;
  logic [NUM_HV-1:0]    hv_req, hv_prev_q;
  logic [NUM_EXT-1:0]   ext_req, ext_prev_q;

  // flag bank widths: one rise and one fall flag per input
  localparam int unsigned HV_FLG_W  = 2 * NUM_HV;
  localparam int unsigned EXT_FLG_W = 2 * NUM_EXT;

  // write data steered to one register, zero elsewhere; the bus signals
  // are arguments so a port connection re-evaluates when they change
  function automatic logic [31:0] wsel(logic we, logic [ADDR_W-1:0] a,
                                       logic [31:0] d,
                                       logic [ADDR_W-1:0] ofs);
    return (we && a == ofs) ? d : 32'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state on every access

  assign acc_go = psel && penable && !pready;
  assign wr_en  = psel && penable && pready && pwrite;

  // ready rises in the second access cycle, then drops again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pready <= 1'b0;
    else pready <= acc_go;
  end

  // read data and error are captured with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RST_REG;
      pslverr <= 1'b0;
    end else begin
      pslverr <= acc_go && !rd_hit; // unmapped address
      if (acc_go && !pwrite) prdata <= rd_hit ? rd_data : RST_REG;
    end
  end

  // read decode; set and clear registers read as zero
  always_comb begin
    rd_data = RST_REG;
    rd_hit  = 1'b1;
    case (paddr)
      OFS_NP_WARN:  rd_data[0]           = np_warn_q;
      OFS_NP_TMR:   rd_data[0]           = np_tmr_q;
      OFS_NP_HV:    rd_data[NUM_HV-1:0]  = np_hv_q;
      OFS_NP_EXT:   rd_data[NUM_EXT-1:0] = np_ext_q;
      OFS_NP_XFER:  rd_data[0]           = np_xfer_q;
      OFS_CLK_EN:   rd_data[NUM_CLK-1:0] = clk_en_q;
      OFS_CLK_ST:   rd_data[NUM_CLK-1:0] = clk_st;
      OFS_HV_EN:    rd_data[NUM_HV-1:0]  = hv_en_q;
      OFS_HV_ST:    rd_data[2*NUM_HV-1:0] = hv_st;
      OFS_HV_CFG:   rd_data[2*NUM_HV-1:0] = hv_cfg_q;
      OFS_EXT_EN:   rd_data[NUM_EXT-1:0] = ext_en_q;
      OFS_EXT_ST:   rd_data[2*NUM_EXT-1:0] = ext_st;
      OFS_EXT_CFG:  rd_data[15:0]        = ext_cfg_q;
      OFS_TMR_EN:   rd_data[NUM_TMR-1:0] = tmr_en_q;
      OFS_TMR_ST:   rd_data[NUM_TMR-1:0] = tmr_st;
      OFS_XFER_EN:  rd_data[8:0]         = xfer_en_q;
      OFS_XFER_ST:  rd_data[NUM_XFER-1:0] = xfer_st;
      OFS_CLK_CLR, OFS_CLK_SET, OFS_HV_CLR, OFS_HV_SET, OFS_EXT_CLR,
      OFS_EXT_SET, OFS_TMR_CLR, OFS_TMR_SET, OFS_XFER_CLR,
      OFS_XFER_SET: rd_hit = 1'b1;
      default:      rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // software control registers

  // node pointers: bit set sends its group, or for sense and pin its one input, to line 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      np_warn_q <= 1'b0;
      np_tmr_q  <= 1'b0;
      np_hv_q   <= '0;
      np_ext_q  <= '0;
      np_xfer_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == OFS_NP_WARN) np_warn_q <= pwdata[0];
      if (paddr == OFS_NP_TMR)  np_tmr_q  <= pwdata[0];
      if (paddr == OFS_NP_HV)   np_hv_q   <= pwdata[NUM_HV-1:0];
      if (paddr == OFS_NP_EXT)  np_ext_q  <= pwdata[NUM_EXT-1:0];
      if (paddr == OFS_NP_XFER) np_xfer_q <= pwdata[0];
    end
  end

  // request enables per source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_en_q  <= '0;
      hv_en_q   <= '0;
      ext_en_q  <= '0;
      xfer_en_q <= '0;
      clk_en_q  <= '0;
    end else if (wr_en) begin
      if (paddr == OFS_TMR_EN)  tmr_en_q  <= pwdata[NUM_TMR-1:0];
      if (paddr == OFS_HV_EN)   hv_en_q   <= pwdata[NUM_HV-1:0];
      if (paddr == OFS_EXT_EN)  ext_en_q  <= pwdata[NUM_EXT-1:0];
      if (paddr == OFS_XFER_EN) xfer_en_q <= pwdata[8:0];
      if (paddr == OFS_CLK_EN)  clk_en_q  <= pwdata[NUM_CLK-1:0];
    end
  end

  // edge and pin source selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_cfg_q  <= '0;
      ext_cfg_q <= '0;
    end else if (wr_en) begin
      if (paddr == OFS_HV_CFG)  hv_cfg_q  <= pwdata[2*NUM_HV-1:0];
      if (paddr == OFS_EXT_CFG) ext_cfg_q <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and filters

  // two flops on every asynchronous sense and pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= {ext_pin_in, hv_sense_comparator_out};
      pin_s_q <= pin_m_q;
    end
  end

  // sense inputs: filter then edge select
  for (genvar i = 0; i < NUM_HV; i++) begin : g_hv
    sia_spike_filter u_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (pin_s_q[i]),
      .rise_o  (hv_rise[i]),
      .fall_o  (hv_fall[i])
    );
    assign hv_hw[i] = hv_rise[i] && hv_cfg_q[2*i+EDGE_RISE_BIT];
    assign hv_hw[i+HV_FALL_LSB] = hv_fall[i] &&
                                  hv_cfg_q[2*i+EDGE_FALL_BIT];
    assign hv_req[i] = (hv_st[i] || hv_st[i+HV_FALL_LSB]) && hv_en_q[i];
  end

  // pin channels: pick A-D, filter, then edge select; a select
  // change can look like an edge, so reprogram with the enable off
  for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
    logic [1:0] sel;
    assign sel = ext_cfg_q[i*EXT_CFG_W+EXT_SEL_LSB +: 2];
    assign ext_pick[i] = pin_s_q[NUM_HV + i*NUM_PIN_SEL + int'(sel)];
    sia_spike_filter u_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ext_pick[i]),
      .rise_o  (ext_rise[i]),
      .fall_o  (ext_fall[i])
    );
    assign ext_hw[i] = ext_rise[i] &&
                       ext_cfg_q[i*EXT_CFG_W+EDGE_RISE_BIT];
    assign ext_hw[i+EXT_FALL_LSB] = ext_fall[i] &&
                                    ext_cfg_q[i*EXT_CFG_W+EDGE_FALL_BIT];
    assign ext_req[i] = (ext_st[i] || ext_st[i+EXT_FALL_LSB]) &&
                        ext_en_q[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // status flag banks

  sia_flag_bank #(.N(NUM_TMR)) u_tmr_st (
    .pclk     (pclk),
    .presetn  (presetn),
    .hw_set_i (timer_evt),
    .sw_set_i (NUM_TMR'(wsel(wr_en, paddr, pwdata, OFS_TMR_SET))),
    .sw_clr_i (NUM_TMR'(wsel(wr_en, paddr, pwdata, OFS_TMR_CLR))),
    .st_o     (tmr_st)
  );

  sia_flag_bank #(.N(2*NUM_HV)) u_hv_st (
    .pclk     (pclk),
    .presetn  (presetn),
    .hw_set_i (hv_hw),
    .sw_set_i (HV_FLG_W'(wsel(wr_en, paddr, pwdata, OFS_HV_SET))),
    .sw_clr_i (HV_FLG_W'(wsel(wr_en, paddr, pwdata, OFS_HV_CLR))),
    .st_o     (hv_st)
  );

  sia_flag_bank #(.N(2*NUM_EXT)) u_ext_st (
    .pclk     (pclk),
    .presetn  (presetn),
    .hw_set_i (ext_hw),
    .sw_set_i (EXT_FLG_W'(wsel(wr_en, paddr, pwdata, OFS_EXT_SET))),
    .sw_clr_i (EXT_FLG_W'(wsel(wr_en, paddr, pwdata, OFS_EXT_CLR))),
    .st_o     (ext_st)
  );

  sia_flag_bank #(.N(NUM_XFER)) u_xfer_st (
    .pclk     (pclk),
    .presetn  (presetn),
    .hw_set_i (transfer_done_evt),
    .sw_set_i (NUM_XFER'(wsel(wr_en, paddr, pwdata, OFS_XFER_SET))),
    .sw_clr_i (NUM_XFER'(wsel(wr_en, paddr, pwdata, OFS_XFER_CLR))),
    .st_o     (xfer_st)
  );

  sia_flag_bank #(.N(NUM_CLK)) u_clk_st (
    .pclk     (pclk),
    .presetn  (presetn),
    .hw_set_i (clock_fault_evt),
    .sw_set_i (NUM_CLK'(wsel(wr_en, paddr, pwdata, OFS_CLK_SET))),
    .sw_clr_i (NUM_CLK'(wsel(wr_en, paddr, pwdata, OFS_CLK_CLR))),
    .st_o     (clk_st)
  );

  ////////////////////////////////////////////////////////////////////////
  // request gating and pulse generation

  assign tmr_req  = tmr_st & tmr_en_q;
  assign xfer_req = {transfer_error_request && xfer_en_q[XFER_ERR_EN_BIT],
                     xfer_st & xfer_en_q[NUM_XFER-1:0]};
  assign clk_req  = clk_st & clk_en_q;

  // previous request levels; a pulse fires only on a new request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_prev_q  <= '0;
      hv_prev_q   <= '0;
      ext_prev_q  <= '0;
      xfer_prev_q <= '0;
      clk_prev_q  <= '0;
    end else begin
      tmr_prev_q  <= tmr_req;
      hv_prev_q   <= hv_req;
      ext_prev_q  <= ext_req;
      xfer_prev_q <= xfer_req;
      clk_prev_q  <= clk_req;
    end
  end

  // edge pulses routed by node pointer, warn events passed straight, nmi unrouted; a request must drop to re-arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq    <= 2'h0;
      hv_sense_irq <= 2'h0;
      ext_pin_irq  <= 2'h0;
      transfer_irq <= 2'h0;
      warn_irq     <= 2'h0;
      nmi_req      <= 1'b0;
    end else begin
      timer_irq    <= sia_route2(16'(tmr_req & ~tmr_prev_q),
                                 {16{np_tmr_q}});
      hv_sense_irq <= sia_route2(16'(hv_req & ~hv_prev_q),
                                 16'(np_hv_q));
      ext_pin_irq  <= sia_route2(16'(ext_req & ~ext_prev_q),
                                 16'(np_ext_q));
      transfer_irq <= sia_route2(16'(xfer_req & ~xfer_prev_q),
                                 {16{np_xfer_q}});
      warn_irq     <= sia_route2(16'(warn_evt), {16{np_warn_q}});
      nmi_req      <= (|(clk_req & ~clk_prev_q)) || mem_fault_evt ||
                      conv_err_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  AST_APB_READY: assert property (s_setup ##1 s_access |=> pready)
    else $error("apb ready not in second access cycle");
  AST_TMR_SWSET: assert property (wr_en && paddr == OFS_TMR_SET &&
    pwdata[0] |=> tmr_st[0]) else $error("timer set write lost");
  AST_TMR_GATE: assert property (timer_irq != 2'h0 |->
    $past(tmr_req) != '0) else $error("timer pulse without enable");
  AST_TMR_LINE: assert property (timer_irq[1] |->
    $past(np_tmr_q)) else $error("timer pulse on wrong line");
  AST_TMR_ROUTE: assert property (timer_evt[0] && tmr_en_q[0] &&
    !tmr_st[0] && !np_tmr_q && !wr_en |=> ##1 timer_irq[0])
    else $error("timer event gave no pulse");
  AST_PULSE_ONCE: assert property (tmr_req == $past(tmr_req) |=>
    timer_irq == 2'h0) else $error("timer request not a pulse");
  AST_XFER_GATE: assert property (transfer_irq != 2'h0 |->
    $past(xfer_req) != '0) else $error("transfer pulse without request");
  AST_NMI_MEM: assert property (mem_fault_evt |=> nmi_req)
    else $error("memory fault not on exception line");
  AST_HV_EDGE: assert property (hv_rise[0] &&
    !hv_cfg_q[EDGE_RISE_BIT] && !wr_en && !hv_st[0] |=> !hv_st[0])
    else $error("unselected sense edge set flag");
endmodule // sia_top
